// [pkg/dscs_pkg.sv]
// Shared constants and types for the read strobe driver.
package dscs_pkg;

	// System clock and link clock periods in picoseconds.
	localparam int unsigned SYS_CLK_PS   = 4000;
	localparam int unsigned LINK_CLK_PS  = 125000;

	// Read latency in link clocks and burst lengths in strobe edges.
	localparam logic [3:0]  RD_LAT       = 4'hb;
	localparam logic [3:0]  BURST_LEN_8  = 4'h8;
	localparam logic [3:0]  BURST_LEN_4  = 4'h4;

	// Minimum link clocks between two column commands from the host.
	localparam logic [3:0]  COL_GAP_CYC  = 4'h4;

	// Strobe preamble and postamble minimums in hundredths of a link clock period.
	localparam int unsigned RD_PRE_MIN_CENT  = 90;
	localparam int unsigned RD_POST_MIN_CENT = 30;
	localparam int unsigned PRE_MIN_CYC  =
		(LINK_CLK_PS * RD_PRE_MIN_CENT / 100 + SYS_CLK_PS - 1) / SYS_CLK_PS;
	localparam int unsigned POST_MIN_CYC =
		(LINK_CLK_PS * RD_POST_MIN_CENT / 100 + SYS_CLK_PS - 1) / SYS_CLK_PS;

	// Column command as seen on the command pins.
	typedef struct packed {
		logic rd;
		logic chop;
	} dscs_cmd_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WAIT  = 4'b0010,
		ST_PRE   = 4'b0100,
		ST_BURST = 4'b1000
	} dscs_state_e;

endpackage : dscs_pkg

// [logic/dscs_rd_strobe.sv]
// Read data strobe driver: preamble, toggling burst, postamble and release.
`timescale 1ns/1ps
module dscs_rd_strobe (
	input  wire logic            i_ref_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_ck,
	input  wire dscs_pkg::dscs_cmd_s i_cmd,
	output logic                 o_dqs,
	output logic                 o_dqs_n,
	output logic                 o_dqs_oe
);
	import dscs_pkg::*;

	// Three-stage samplers for the link clock and the command pins.
	logic [2:0]  ck_sync_q;
	logic [2:0]  rd_sync_q;
	logic [2:0]  chop_sync_q;
	logic        ck_lvl_q;
	logic        ck_lvl_d;
	logic        ck_rise;
	logic        ck_fall;
	logic        rd_lvl_q;
	logic        rd_lvl_d;
	logic        chop_lvl_q;
	logic        chop_lvl_d;

	dscs_state_e state_q;
	dscs_state_e state_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [3:0]  blen_q;
	logic [3:0]  blen_d;
	logic        dqs_q;
	logic        dqs_d;
	logic        oe_q;
	logic        oe_d;
	logic [7:0]  dwell_q;
	logic [7:0]  dwell_d;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ck_sync_q   <= 3'h0;
			rd_sync_q   <= 3'h0;
			chop_sync_q <= 3'h0;
		end else begin
			ck_sync_q   <= {ck_sync_q[1:0], i_ck};
			rd_sync_q   <= {rd_sync_q[1:0], i_cmd.rd};
			chop_sync_q <= {chop_sync_q[1:0], i_cmd.chop};
		end
	end

	// A pin level counts only once the last two stages agree, so a sample caught
	// mid-transition cannot make a false link edge or a false command.
	always_comb begin
		ck_lvl_d   = ck_lvl_q;
		rd_lvl_d   = rd_lvl_q;
		chop_lvl_d = chop_lvl_q;
		if (ck_sync_q[1] == ck_sync_q[2]) begin
			ck_lvl_d = ck_sync_q[2];
		end
		if (rd_sync_q[1] == rd_sync_q[2]) begin
			rd_lvl_d = rd_sync_q[2];
		end
		if (chop_sync_q[1] == chop_sync_q[2]) begin
			chop_lvl_d = chop_sync_q[2];
		end
		ck_rise = ck_lvl_d & ~ck_lvl_q;
		ck_fall = ~ck_lvl_d & ck_lvl_q;
	end

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		blen_d  = blen_q;
		dqs_d   = dqs_q;
		oe_d    = oe_q;
		dwell_d = (dwell_q == 8'hff) ? dwell_q : dwell_q + 8'h01;
		unique case (state_q)
			ST_IDLE: begin
				// Commands are taken at a rising link clock; a new read while busy is ignored.
				if (ck_rise && rd_lvl_d) begin
					state_d = ST_WAIT;
					cnt_d   = 4'h0;
					blen_d  = chop_lvl_d ? BURST_LEN_4 : BURST_LEN_8;
				end
			end
			ST_WAIT: begin
				if (ck_rise) begin
					if (cnt_q == RD_LAT - 4'h2) begin
						state_d = ST_PRE;
						oe_d    = 1'b1;
						dqs_d   = 1'b0;
						dwell_d = 8'h00;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			ST_PRE: begin
				if (ck_rise) begin
					state_d = ST_BURST;
					dqs_d   = 1'b1;
					cnt_d   = 4'h0;
				end
			end
			ST_BURST: begin
				if (ck_rise || ck_fall) begin
					cnt_d = cnt_q + 4'h1;
					if (ck_rise && cnt_q + 4'h1 == blen_q) begin
						state_d = ST_IDLE;
						oe_d    = 1'b0;
						dqs_d   = 1'b0;
					end else begin
						dqs_d = ~dqs_q;
					end
					// Half-clock postamble: the last fall parks the strobe low.
					dwell_d = 8'h00;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ck_lvl_q <= 1'b0;
			rd_lvl_q   <= 1'b0;
			chop_lvl_q <= 1'b0;
			state_q  <= ST_IDLE;
			cnt_q    <= 4'h0;
			blen_q   <= BURST_LEN_8;
			dqs_q    <= 1'b0;
			oe_q     <= 1'b0;
			dwell_q  <= 8'h00;
		end else begin
			ck_lvl_q <= ck_lvl_d;
			rd_lvl_q   <= rd_lvl_d;
			chop_lvl_q <= chop_lvl_d;
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			blen_q   <= blen_d;
			dqs_q    <= dqs_d;
			oe_q     <= oe_d;
			dwell_q  <= dwell_d;
		end
	end

	// Both strobe legs come from flops so the pair switches together.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_dqs    <= 1'b0;
			o_dqs_n  <= 1'b1;
			o_dqs_oe <= 1'b0;
		end else begin
			o_dqs    <= dqs_d;
			o_dqs_n  <= ~dqs_d;
			o_dqs_oe <= oe_d;
		end
	end

	property p_pre_len;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_q == ST_PRE && state_d == ST_BURST) |-> dwell_q >= 8'(PRE_MIN_CYC - 1);
	endproperty
	a_pre_len: assert property (p_pre_len) else $error("read preamble too short");

	property p_post_len;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_q == ST_BURST && state_d == ST_IDLE) |-> !dqs_q && dwell_q >= 8'(POST_MIN_CYC - 1);
	endproperty
	a_post_len: assert property (p_post_len) else $error("read postamble too short");

	property p_drive_start;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(o_dqs_oe) |-> $past(state_q) == ST_WAIT && $past(cnt_q) == RD_LAT - 4'h2
			&& !o_dqs && o_dqs_n;
	endproperty
	a_drive_start: assert property (p_drive_start) else $error("strobe driven at wrong cycle");

	property p_release;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$fell(o_dqs_oe) |-> $past(state_q) == ST_BURST && $past(cnt_q) + 4'h1 == $past(blen_q)
			&& ck_lvl_q;
	endproperty
	a_release: assert property (p_release) else $error("strobe released at wrong cycle");

	property p_first_high;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_q == ST_PRE && state_d == ST_BURST) |=> o_dqs && !o_dqs_n && o_dqs_oe;
	endproperty
	a_first_high: assert property (p_first_high) else $error("no first strobe rise");

	property p_edge_only;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_q == ST_BURST && !ck_rise && !ck_fall) |=> $stable(o_dqs);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("strobe moved off a link edge");

	property p_park_low;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$fell(o_dqs_oe) |-> !o_dqs && !$past(o_dqs);
	endproperty
	a_park_low: assert property (p_park_low) else $error("strobe not low at release");

endmodule : dscs_rd_strobe

// [tb/dscs_host_model.sv]
// Host model: free-running link clock and read command pins.
`timescale 1ns/1ps
module dscs_host_model (
	input  wire logic           i_go,
	input  wire logic           i_chop,
	output logic                o_ck,
	output dscs_pkg::dscs_cmd_s o_cmd
);
	import dscs_pkg::*;
	logic        ck_q  = 1'b0;
	dscs_cmd_s   cmd_q = '0;
	logic [3:0]  gap_q = 4'h0;
	assign o_ck  = ck_q;
	assign o_cmd = cmd_q;
	// The offset keeps link edges off every system clock edge, avoiding races.
	initial begin
		#1.25;
		forever #62.5 ck_q = ~ck_q;
	end
	// Column gap countdown.
	// Pins change only at link falls so each command straddles one rise.
	always @(negedge ck_q) begin
		if (gap_q != 4'h0) begin
			gap_q      <= gap_q - 4'h1;
			cmd_q.rd   <= 1'b0;
			cmd_q.chop <= 1'b0;
		end else begin
			gap_q      <= i_go ? COL_GAP_CYC - 4'h1 : 4'h0;
			cmd_q.rd   <= i_go;
			cmd_q.chop <= i_go & i_chop;
		end
	end
	// It sends no mode or activate commands.
endmodule : dscs_host_model

// [tb/dscs_rd_strobe_tb.sv]
// Self-checking testbench for the read strobe driver.
`timescale 1ns/1ps
module dscs_rd_strobe_tb;
	import dscs_pkg::*;
	logic      i_ref_clk, i_sys_rst, go, chop, ck, dqs, dqs_n, oe;
	dscs_cmd_s cmd;
	int        n_errors, total_checks;
	realtime   t_oe_up, t_oe_dn, t_hi, t_lo;
	localparam int PRE_PS  = LINK_CLK_PS * RD_PRE_MIN_CENT / 100;
	localparam int POST_PS = LINK_CLK_PS * RD_POST_MIN_CENT / 100;
	dscs_rd_strobe dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ck(ck),
		.i_cmd(cmd), .o_dqs(dqs), .o_dqs_n(dqs_n), .o_dqs_oe(oe));
	dscs_host_model host (.i_go(go), .i_chop(chop), .o_ck(ck), .o_cmd(cmd));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic chk_min(input string what, input int lim, input int got);
		total_checks++;
		if (got < lim) begin
			n_errors++;
			$display("MISMATCH %s expected at least %0d seen %0d", what, lim, got);
		end
	endtask : chk_min
	// Strobe event times, used to measure preamble and postamble widths.
	always @(posedge oe) t_oe_up = $realtime;
	always @(negedge oe) t_oe_dn = $realtime;
	always @(posedge dqs) t_hi = $realtime;
	always @(negedge dqs) t_lo = $realtime;
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic do_read(input logic [3:0] bl);
		logic [7:0] n_lo, n_hi, n_ed;
		n_lo = 8'h00;
		n_hi = 8'h00;
		n_ed = 8'h00;
		@(negedge i_ref_clk);
		go   = 1'b1;
		chop = (bl == BURST_LEN_4);
		for (int k = 0; k < 80 && cmd.rd !== 1'b1; k++)
			@(negedge i_ref_clk);
		go = 1'b0;
		chk("cmd", 8'h01, {7'h00, cmd.rd});
		// Falls seen with the strobe still released count the lead time.
		while (oe !== 1'b1 && n_lo < 8'h28) begin
			@(negedge ck);
			n_lo += (oe !== 1'b1);
		end
		chk("lead", {4'h0, RD_LAT} - 8'h01, n_lo);
		if (oe !== 1'b1)
			return;
		chk("pre", 8'h00, {7'h00, dqs});
		do begin
			@(ck);
			n_ed++;
			n_hi += dqs;
			if (dqs === 1'b1 && n_hi == 8'h01)
				chk_min("pre_ps", PRE_PS, int'((t_hi - t_oe_up) * 1000.0));
			chk("pair", {7'h00, ~dqs}, {7'h00, dqs_n});
		end while (oe === 1'b1 && n_ed < 8'h28);
		chk("release", {4'h0, bl} + 8'h02, n_ed);
		chk("pulses", {5'h00, bl[3:1]}, n_hi);
		chk("post", 8'h00, {7'h00, dqs});
		chk_min("post_ps", POST_PS, int'((t_oe_dn - t_lo) * 1000.0));
	endtask : do_read
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		n_errors     = 0;
		total_checks = 0;
		i_sys_rst    = 1'b1;
		go           = 1'b0;
		chop         = 1'b0;
		repeat (20) @(negedge i_ref_clk);
		chk("rst_oe", 8'h00, {7'h00, oe});
		chk("rst_dqs_n", 8'h01, {7'h00, dqs_n});
		i_sys_rst = 1'b0;
		do_read(BURST_LEN_8);
		do_read(BURST_LEN_4);
		complete_run();
	end
endmodule : dscs_rd_strobe_tb
